//--- rtl/plane_row_column_adder.sv
// Bit-plane datapath: accumulator save-and-invert and row/column ripple addition of C and Q planes.
// Assumes the array control unit presents decoded instructions synchronous to ref_clk.
//
// Functional notes
// RULE1 - Save-then-invert copies Q into C, then complements all of Q.
// RULE2 - Add-keep-sum adds C and Q lines, sum to Q, carry-outs to C.
// RULE3 - Carry-only adds the same way but writes only carry-outs; Q stays.
// RULE4 - Direction, geometry and count come from instruction fields plus selected index register.
// RULE5 - Issuer encodes default direction code when none given, and selects a register.
// RULE6 - Issuer with no geometry picks register-sourced wrap shape and selects a register.
// RULE7 - Issuer encodes zero propagation span when no count is given.
// RULE8 - North or south adds column pairs, carries rippling toward that edge.
// RULE9 - East or west adds row pairs, carries rippling toward that edge.
// RULE10 - Significance rises in propagation direction; LSB at the opposite edge.
// RULE11 - Plane carry-in is zero; cyclic carry-in is the same line's MSB carry-out.
// RULE12 - Each bit adds original Q, original C and the lower carry-out.
// RULE13 - Carry is known where C equals Q, and outside LSB edge for plane.
// RULE14 - Sums guaranteed count-plus-one places above known points; carries there too.
// RULE15 - Maximum count gives a full correct line under plane geometry.
// RULE16 - Cyclic with Q the complement of C guarantees nothing.
// RULE17 - Count may be ignored with full ripple; issuers still supply one.
// RULE18 - Lines are edge_size bits wide, fixed by package constant.
// RULE19 - Positions outside the span may hold anything; exact full sums are fine.
`timescale 1ns/1ps
module plane_row_column_adder
  import plane_adder_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   clkEn,
  input  wire logic                   instrValid,
  input  wire instr_s                 instr,
  input  wire word_t [IDX_REGS-1:0]   indexRegs,
  input  wire logic                   loadQ,
  input  wire logic                   loadC,
  input  wire plane_t                 loadData,
  output plane_t                      qPlane_r,
  output plane_t                      cPlane_r,
  output logic                        ready_r,
  output logic                        done_r,
  output effect_s                     effect_r,
  output line_t                       knownCarry_r
);

  // Resolve the effective parameters from the instruction and the selected register
  function automatic effect_s resolve(instr_s ins, word_t rv);
    effect_s e;
    logic [SPAN_W:0] cnt;
    if (ins.carryWay < DEFAULT_DIRECTION_CODE) begin
      e.dir = ins.carryWay[1:0]; // RULE4
    end else begin
      e.dir = 2'(rv[REG_DIR_LSB +: 2] + ins.carryWay[1:0]); // RULE4 RULE5
    end
    if (ins.wrapShape == WRAP_PLANE) begin
      e.cyclic = 1'b0;
    end else if (ins.wrapShape == WRAP_CYCLIC) begin
      e.cyclic = 1'b1;
    end else begin
      e.cyclic = rv[REG_GEOM_BIT]; // RULE6
    end
    cnt = {1'b0, ins.span} + {1'b0, rv[REG_COUNT_LSB +: SPAN_W]}; // RULE4 RULE7
    e.count = cnt[SPAN_W] ? SPAN_FULL : cnt[SPAN_W-1:0];
    return e;
  endfunction : resolve

  // Line j, bit k in propagation order, for each direction
  function automatic plane_t gather(plane_t p, logic [1:0] dir);
    plane_t l;
    for (int j = 0; j < EDGE_SIZE; j++) begin
      for (int k = 0; k < EDGE_SIZE; k++) begin
        case (dir)
          WAY_NORTH[1:0]: l[j][k] = p[EDGE_SIZE-1-k][j]; // RULE8 RULE10
          WAY_SOUTH[1:0]: l[j][k] = p[k][j]; // RULE8 RULE10
          WAY_EAST[1:0]:  l[j][k] = p[j][k]; // RULE9 RULE10
          default:        l[j][k] = p[j][EDGE_SIZE-1-k]; // RULE9 RULE10
        endcase
      end
    end
    return l;
  endfunction : gather

  function automatic plane_t scatter(plane_t l, logic [1:0] dir);
    plane_t p;
    for (int j = 0; j < EDGE_SIZE; j++) begin
      for (int k = 0; k < EDGE_SIZE; k++) begin
        case (dir)
          WAY_NORTH[1:0]: p[EDGE_SIZE-1-k][j] = l[j][k];
          WAY_SOUTH[1:0]: p[k][j] = l[j][k];
          WAY_EAST[1:0]:  p[j][k] = l[j][k];
          default:        p[j][EDGE_SIZE-1-k] = l[j][k];
        endcase
      end
    end
    return p;
  endfunction : scatter

  state_e  state_r;
  state_e  state_nxt;
  word_t   selReg;
  effect_s eff;
  plane_t  qLines;
  plane_t  cLines;
  plane_t  sumLines;
  plane_t  carryLines;
  plane_t  sumPlane;
  plane_t  carryPlane;
  line_t   knownNow;
  logic    take;
  logic    isAdd;
  logic    isSave;
  plane_t  qPlane_nxt;
  plane_t  cPlane_nxt;

  // Selection code zero means no index register; its contribution is zero
  assign selReg = (instr.idxSel == SEL_NONE) ? '0 : indexRegs[instr.idxSel];
  assign eff    = resolve(instr, selReg);

  assign take   = instrValid & (state_r == ST_IDLE);
  assign isAdd  = take & ((instr.op == OP_ADD_KEEP) | (instr.op == OP_CARRY_ONLY));
  assign isSave = take & (instr.op == OP_SAVE_INVERT);

  // Operands are taken from the registered planes, so nothing is overwritten before use
  assign qLines = gather(qPlane_r, eff.dir); // RULE12
  assign cLines = gather(cPlane_r, eff.dir); // RULE12

  // Full ripple in every line; the effective count only reports, it never truncates
  genvar g;
  generate
    for (g = 0; g < EDGE_SIZE; g++) begin : g_line
      line_adder u_line (
        .a      (qLines[g]),
        .b      (cLines[g]),
        .cyclic (eff.cyclic),
        .sum    (sumLines[g]),
        .carry  (carryLines[g])
      ); // RULE17 RULE18
    end
  endgenerate

  assign sumPlane   = scatter(sumLines, eff.dir);
  assign carryPlane = scatter(carryLines, eff.dir);

  // Lines that hold at least one known carry point, reported per line index
  generate
    for (g = 0; g < EDGE_SIZE; g++) begin : g_known
      assign knownNow[g] = ~eff.cyclic | (|(~(qLines[g] ^ cLines[g]))); // RULE13 RULE16
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (isSave) begin
          state_nxt = ST_INVERT;
        end
      end
      ST_INVERT: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Loads from the array are lower priority than an executing operation
  always_comb begin
    qPlane_nxt = qPlane_r;
    cPlane_nxt = cPlane_r;
    if (state_r == ST_INVERT) begin
      qPlane_nxt = ~qPlane_r; // RULE1
    end else if (isSave) begin
      cPlane_nxt = qPlane_r; // RULE1
    end else if (isAdd) begin
      cPlane_nxt = carryPlane; // RULE2 RULE3 RULE14
      if (instr.op == OP_ADD_KEEP) begin
        qPlane_nxt = sumPlane; // RULE2 RULE14
      end
    end else begin
      if (loadQ) begin
        qPlane_nxt = loadData;
      end
      if (loadC) begin
        cPlane_nxt = loadData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      done_r  <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == ST_IDLE);
      done_r  <= isAdd | (state_r == ST_INVERT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      qPlane_r <= '0;
      cPlane_r <= '0;
    end else if (clkEn) begin
      qPlane_r <= qPlane_nxt;
      cPlane_r <= cPlane_nxt;
    end
  end

  // Effective parameters and known-carry map are captured for each addition
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      effect_r     <= '0;
      knownCarry_r <= '0;
    end else if (clkEn && isAdd) begin
      effect_r     <= eff;
      knownCarry_r <= knownNow;
    end
  end

endmodule : plane_row_column_adder

//--- rtl/plane_adder_pkg.sv
// Package for the bit-plane row/column adder: geometry, instruction and result types, field codes.
// Assumes a single array clock; planes are square with EDGE_SIZE bits on a side.
package plane_adder_pkg;

  localparam int EDGE_SIZE = 32;
  localparam int SPAN_W    = 5;
  localparam int SEL_W     = 4;
  localparam int IDX_REGS  = 16;
  localparam int REG_W     = 32;

  typedef logic [EDGE_SIZE-1:0] line_t;
  typedef line_t [EDGE_SIZE-1:0] plane_t;
  typedef logic [REG_W-1:0]     word_t;

  // Carry way codes: 0..3 name an edge, 4..7 add their low two bits to the edge in the index register
  localparam logic [2:0] WAY_NORTH              = 3'h0;
  localparam logic [2:0] WAY_EAST               = 3'h1;
  localparam logic [2:0] WAY_SOUTH              = 3'h2;
  localparam logic [2:0] WAY_WEST               = 3'h3;
  localparam logic [2:0] DEFAULT_DIRECTION_CODE = 3'h4;

  // Wrap shape codes
  localparam logic [1:0] WRAP_PLANE    = 2'h0;
  localparam logic [1:0] WRAP_CYCLIC   = 2'h1;
  localparam logic [1:0] WRAP_FROM_REG = 2'h2;

  // Field positions inside the selected index register
  localparam int REG_DIR_LSB   = 0;
  localparam int REG_GEOM_BIT  = 2;
  localparam int REG_COUNT_LSB = 8;

  localparam logic [SEL_W-1:0]  SEL_NONE  = 4'h0;
  localparam logic [SPAN_W-1:0] SPAN_FULL = 5'h1f;

  typedef enum logic [2:0] {
    OP_SAVE_INVERT = 3'b001,
    OP_ADD_KEEP    = 3'b010,
    OP_CARRY_ONLY  = 3'b100
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_INVERT = 2'b10
  } state_e;

  typedef struct packed {
    op_e               op;
    logic [2:0]        carryWay;
    logic [1:0]        wrapShape;
    logic [SPAN_W-1:0] span;
    logic [SEL_W-1:0]  idxSel;
  } instr_s;

  typedef struct packed {
    logic [1:0]        dir;
    logic              cyclic;
    logic [SPAN_W-1:0] count;
  } effect_s;

endpackage : plane_adder_pkg

//--- rtl/line_adder.sv
// One row or column adder: EDGE_SIZE-bit unsigned add with plane or cyclic carry-in.
// Assumes operands already ordered with bit 0 least significant; purely combinational.
`timescale 1ns/1ps
module line_adder
  import plane_adder_pkg::*;
(
  input  wire line_t a,
  input  wire line_t b,
  input  wire logic  cyclic,
  output line_t      sum,
  output line_t      carry
);

  function automatic line_t ripple(line_t x, line_t y, logic cin);
    line_t res;
    logic  c;
    c = cin;
    for (int k = 0; k < EDGE_SIZE; k++) begin
      c = (x[k] & y[k]) | (c & (x[k] ^ y[k])); // RULE12
      res[k] = c;
    end
    return res;
  endfunction : ripple

  line_t carryZero;
  logic  cin;

  // A cyclic wrap would be a combinational loop; instead pick the self-consistent carry-in.
  // If the zero-in pass carries out, a one-in pass carries out too, so one-in is consistent.
  assign carryZero = ripple(a, b, 1'b0);
  assign cin       = cyclic & carryZero[EDGE_SIZE-1]; // RULE11 RULE16
  assign carry     = ripple(a, b, cin); // RULE15 RULE19
  assign sum       = a ^ b ^ {carry[EDGE_SIZE-2:0], cin}; // RULE2

endmodule : line_adder

//--- sim/plane_adder_checker.sv
// Checker for the plane adder: instruction take, plane effects and reported parameters.
// Assumes it is bound to plane_row_column_adder and sees only its ports.
`timescale 1ns/1ps
module plane_adder_checker
  import plane_adder_pkg::*;
(
  input wire logic    ref_clk,
  input wire logic    rst,
  input wire logic    clkEn,
  input wire logic    instrValid,
  input wire instr_s  instr,
  input wire plane_t  qPlane_r,
  input wire plane_t  cPlane_r,
  input wire logic    ready_r,
  input wire logic    done_r,
  input wire effect_s effect_r,
  input wire line_t   knownCarry_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic take = clkEn && instrValid && ready_r;
  sequence s_save; take && instr.op == OP_SAVE_INVERT; endsequence
  sequence s_add; take && instr.op != OP_SAVE_INVERT; endsequence
  property p_save_copy; s_save |=> cPlane_r == $past(qPlane_r) && !ready_r; endproperty
  a_save_copy: assert property (p_save_copy) else $error("C did not take Q");
  property p_save_inv; s_save ##1 clkEn |=> qPlane_r == ~$past(cPlane_r) && done_r; endproperty
  a_save_inv: assert property (p_save_inv) else $error("Q not inverted");
  property p_invert_once; !ready_r && clkEn |=> ready_r; endproperty
  a_invert_once: assert property (p_invert_once) else $error("Invert step too long");
  property p_keep_q; take && instr.op == OP_CARRY_ONLY |=> qPlane_r == $past(qPlane_r); endproperty
  a_keep_q: assert property (p_keep_q) else $error("Q changed by carry-only add");
  property p_add_done; s_add |=> done_r && ready_r; endproperty
  a_add_done: assert property (p_add_done) else $error("Add not completed");
  property p_way; (s_add and !instr.carryWay[2]) |=> effect_r.dir == $past(instr.carryWay[1:0]); endproperty
  a_way: assert property (p_way) else $error("Wrong direction");
  property p_wrap; (s_add and !instr.wrapShape[1]) |=> effect_r.cyclic == $past(instr.wrapShape[0]); endproperty
  a_wrap: assert property (p_wrap) else $error("Wrong geometry");
  property p_plane_known; s_add |=> effect_r.cyclic || knownCarry_r == 32'hffffffff; endproperty
  a_plane_known: assert property (p_plane_known) else $error("Plane line lacks known carry");
  // A low enable must hold Q, C, done, ready and effect_r, the pending invert step included
  property p_freeze;
    !clkEn |=> $stable(qPlane_r) && $stable(cPlane_r) && $stable(done_r) && $stable(ready_r) && $stable(effect_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while clock enable low");
endmodule : plane_adder_checker
bind plane_row_column_adder plane_adder_checker u_chk (.ref_clk, .rst, .clkEn, .instrValid, .instr, .qPlane_r,
  .cPlane_r, .ready_r, .done_r, .effect_r, .knownCarry_r);

//--- sim/ctrl_issue_model.sv
// Control-unit side: encodes decoded instructions, filling the fields the issuer left out.
// Assumes the bench gives operand fields and a mask of which ones are present.
`timescale 1ns/1ps
module ctrl_issue_model
  import plane_adder_pkg::*;
(
  input  wire op_e               op,
  input  wire logic [2:0]        way,
  input  wire logic [1:0]        wrap,
  input  wire logic [SPAN_W-1:0] span,
  input  wire logic [SEL_W-1:0]  sel,
  input  wire logic [2:0]        given,
  output instr_s                 instr
);
  wire logic [2:0]        wayEnc  = given[0] ? way : DEFAULT_DIRECTION_CODE;
  wire logic [1:0]        wrapEnc = given[1] ? wrap : WRAP_FROM_REG;
  wire logic [SPAN_W-1:0] spanEnc = given[2] ? span : 5'h0;
  assign instr = '{op, wayEnc, wrapEnc, spanEnc, sel};
endmodule : ctrl_issue_model

//--- sim/tb_top.sv
// Bench for the plane adder: random planes, every direction and wrap, save-invert, indexed forms.
// Assumes the package constants; expected planes queue up and are checked when done_r shows with clkEn high at the last edge.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t bad result", $time); end end
module tb_top;
  import plane_adder_pkg::*;
  typedef struct packed { plane_t q; plane_t c; effect_s e; line_t k; } exp_s;
  logic                ref_clk = 0;
  logic                rst = 1;
  logic                clkEn = 1'b1;
  logic                enSeen = 1'b0;
  logic                instrValid = 0;
  logic                loadQ = 0;
  logic                loadC = 0;
  plane_t              loadData = '0;
  word_t [IDX_REGS-1:0] indexRegs = '0;
  op_e                 op = OP_ADD_KEEP;
  logic [2:0]          way = 3'h0;
  logic [2:0]          given = 3'h7;
  logic [1:0]          wrap = 2'h0;
  logic [SEL_W-1:0]    sel = 4'h0;
  instr_s              instr;
  plane_t              qPlane_r, cPlane_r;
  logic                ready_r, done_r;
  effect_s             effect_r;
  line_t               knownCarry_r;
  exp_s                cur = '0, got, expQ[$];
  int                  fail_count = 0, tests_run = 0;
  integer              seed = 88;
  ctrl_issue_model u_cu (.op(op), .way(way), .wrap(wrap), .span(SPAN_FULL), .sel(sel), .given(given), .instr(instr));
  // Clock enable drops for two cycles in every load sequence, so frozen results must not be checked twice
  plane_row_column_adder u_dut (.ref_clk, .rst, .clkEn, .instrValid, .instr, .indexRegs, .loadQ, .loadC,
    .loadData, .qPlane_r, .cPlane_r, .ready_r, .done_r, .effect_r, .knownCarry_r);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic int rr(int d, int j, int k); return d == 0 ? 31 - k : d == 2 ? k : j; endfunction : rr
  function automatic int cc(int d, int j, int k); return d == 1 ? k : d == 3 ? 31 - k : j; endfunction : cc
  task automatic issue(op_e o, logic [2:0] w, logic [1:0] wr, logic [3:0] s, logic [2:0] g);
    word_t r; logic [2:0] we; logic [1:0] pe; logic [5:0] n; exp_s e; line_t a, b, x; logic [32:0] t; int d;
    r = (s == SEL_NONE) ? 32'h0 : indexRegs[s];
    we = g[0] ? w : DEFAULT_DIRECTION_CODE;
    pe = g[1] ? wr : WRAP_FROM_REG;
    n = (g[2] ? SPAN_FULL : 5'h0) + r[12:8];
    e = cur;
    if (o == OP_SAVE_INVERT) begin
      e.c = cur.q;
      e.q = ~cur.q;
    end else begin
      d = we[2] ? (r[1:0] + we[1:0]) % 4 : we[1:0];
      e.e = '{d[1:0], pe[1] ? r[2] : pe[0], n > 31 ? 5'h1f : n[4:0]};
      for (int j = 0; j < 32; j++) begin
        for (int k = 0; k < 32; k++) begin
          a[k] = cur.q[rr(d, j, k)][cc(d, j, k)];
          b[k] = cur.c[rr(d, j, k)][cc(d, j, k)];
        end
        t = a + b;
        // Cyclic carry-in is the only self-consistent value once any carry is known
        if (e.e.cyclic && t[32]) t = a + b + 33'h1;
        x = a ^ b ^ t[31:0];
        e.k[j] = !e.e.cyclic || ~(a ^ b) != 0;
        for (int k = 0; k < 32; k++) begin
          if (o == OP_ADD_KEEP) e.q[rr(d, j, k)][cc(d, j, k)] = t[k];
          e.c[rr(d, j, k)][cc(d, j, k)] = (k == 31) ? t[32] : x[k + 1];
        end
      end
    end
    cur = e;
    expQ.push_back(e);
    op <= o; way <= w; wrap <= wr; sel <= s; given <= g; instrValid <= 1'b1;
    @(negedge ref_clk);
    while (ready_r !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask : issue
  task automatic load_both(bit inv);
    plane_t p, v;
    for (int j = 0; j < 32; j++) p[j] = $random(seed);
    for (int j = 0; j < 32; j++) v[j] = inv ? ~p[j] : $random(seed);
    instrValid <= 1'b0;
    clkEn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    clkEn <= 1'b1;
    @(posedge ref_clk);
    loadQ <= 1'b1; loadData <= p; cur.q = p;
    @(posedge ref_clk);
    loadQ <= 1'b0; loadC <= 1'b1; loadData <= v; cur.c = v;
    @(posedge ref_clk);
    loadC <= 1'b0;
  endtask : load_both
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) enSeen <= clkEn;
  always @(negedge ref_clk) begin
    if (done_r === 1'b1 && enSeen === 1'b1) begin
      `CHK(expQ.size() != 0, 1'b1)
      if (expQ.size() != 0) begin
        got = expQ.pop_front();
        `CHK(qPlane_r, got.q)
        `CHK(cPlane_r, got.c)
        `CHK(effect_r, got.e)
        `CHK(knownCarry_r, got.k)
      end
    end
  end
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < IDX_REGS; i++) indexRegs[i] <= $random(seed) & 32'h1f07;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) begin
      load_both(1'b0);
      for (int d = 0; d < 4; d++) issue(OP_ADD_KEEP, 3'(d), WRAP_PLANE, 4'h0, 3'h7);
      for (int d = 0; d < 4; d++) issue(OP_CARRY_ONLY, 3'(d), WRAP_CYCLIC, 4'h0, 3'h7);
      issue(OP_SAVE_INVERT, 3'h0, 2'h0, 4'h0, 3'h7);
      for (int w = 4; w < 8; w++) issue(OP_ADD_KEEP, 3'(w), WRAP_PLANE, 4'(w + 4), {w[0], 1'b0, w != 4});
      issue(OP_CARRY_ONLY, 3'h1, 2'h3, 4'hf, 3'h7);
    end
    // Q as the exact complement of C leaves cyclic lines with no known carry
    load_both(1'b1);
    issue(OP_ADD_KEEP, 3'h1, WRAP_CYCLIC, 4'h0, 3'h7);
    load_both(1'b0);
    `CHK(expQ.size(), 0)
    report_and_stop();
  end
endmodule : tb_top
